// ==== ftm_defs.vh ====
// constants for the fault tolerant memory translator
// assumes a single 200 MHz clock and an apb register bus
// Function
// [R1] 13-bit address selects one of 8192 words
// [R2] requester gives 16 data plus 2 odd parity
// [R3] bad write parity: flag, read instead
// [R4] good parity: store data with six check bits
// [R5] read loads register, checks, makes byte parity
// [R6] single error lights one bit indicator only
// [R7] double error lights double indicator only
// [R8] per-bit stuck-at-one or zero on read word
// [R9] two 4-bit translator fault selectors
// [R10] selected fault inverts line; right 14 fails corrector
// [R11] single cycle per start, or free run
// [R12] reconfigure: read, correct, write spare and plane
// [R13] start address, word count, spare code registers
// [R14] writing word count starts reconfiguration
// [R15] spare code is parity-check column code
// [R16] one spare only; spare select ignored
// [R17] write complete set after write, cleared next cycle
// [R18] busy and cycle_status_a high during each cycle
// [R19] spare display lights assigned bit position
// [R20] data display shows register input
// [R21] latch reset clears error latches; master all
// [R22] reconfig steps address, counts down to zero
// [R23] hsiao style secded code over 22 bits
`ifndef FTM_DEFS_VH
`define FTM_DEFS_VH
`define A_CTRL 12'h000
`define A_ADDR 12'h004
`define A_WDATA 12'h008
`define A_FAULT1 12'h00c
`define A_FAULT0 12'h010
`define A_TSEL 12'h014
`define A_RSTART 12'h018
`define A_RSPARE 12'h01c
`define A_RCOUNT 12'h020
`define A_STATUS 12'h024
`define A_RDATA 12'h028
`define A_BITERR 12'h02c
`define A_DISP 12'h030
`define A_CMD 12'h034
`define C_RW 0
`define C_FREE 1
`define C_DSPARE 2
`define C_DDATA 3
`define K_START 0
`define K_ELRST 1
`define FREE_NS 1667
`define CLK_NS 5
`define WORDS 8192
`endif

// ==== ftm.v ====
// fault tolerant memory translator with apb register access
// assumes synchronous active-low reset and flop-based storage
//
// The register offsets and register access over APB were decided locally.
`default_nettype none
`include "ftm_defs.vh"
module ftm (
    input wire mclk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire busy,
    output wire cycle_status_a,
    output reg write_complete_q,
    output reg host_parity_err_q,
    output reg double_err_q,
    output wire [21:0] bit_error_row,
    output wire [15:0] data_display
);
    localparam [15:0] FREE_CYC = (`FREE_NS + `CLK_NS - 1) / `CLK_NS;
    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_READ = 2'd1;
    localparam [1:0] S_WRITE = 2'd2;
    reg [21:0] storage_module [0:`WORDS-1];
    reg [3:0] ctrl_q;
    reg [12:0] addr_q;
    reg [17:0] wdata_q;
    reg [21:0] f1_q, f0_q;
    reg [7:0] tsel_q;
    reg [12:0] rstart_q, rcount_q;
    reg [5:0] rspare_q;
    reg recon_q;
    reg [1:0] st_q;
    reg [12:0] cyc_addr_q;
    reg cyc_wr_q;
    reg [21:0] storage_data_register;
    reg [21:0] bit_err_q;
    reg corr_fail_q;
    reg [15:0] free_cnt_q;
    reg start_q;
    // hsiao column codes, one per stored bit
    function [5:0] col;
        input [4:0] i;
        begin
            case (i)
                5'd0: col = 6'h07; 5'd1: col = 6'h0b; 5'd2: col = 6'h0d;
                5'd3: col = 6'h0e; 5'd4: col = 6'h13; 5'd5: col = 6'h15;
                5'd6: col = 6'h16; 5'd7: col = 6'h19; 5'd8: col = 6'h1a;
                5'd9: col = 6'h1c; 5'd10: col = 6'h23; 5'd11: col = 6'h25;
                5'd12: col = 6'h26; 5'd13: col = 6'h29; 5'd14: col = 6'h2a;
                5'd15: col = 6'h2c; 5'd16: col = 6'h01; 5'd17: col = 6'h02;
                5'd18: col = 6'h04; 5'd19: col = 6'h08; 5'd20: col = 6'h10;
                default: col = 6'h20;
            endcase
        end
    endfunction
    function [5:0] synd;
        input [21:0] w;
        integer i;
        begin
            synd = 6'h00;
            for (i = 0; i < 22; i = i + 1)
                if (w[i])
                    synd = synd ^ col(i[4:0]); // R23
        end
    endfunction
    function [5:0] checks;
        input [15:0] d;
        begin
            checks = synd({6'h00, d}); // R4
        end
    endfunction
    // apb
    wire wr = psel & penable & pwrite;
    wire rd_acc = psel & ~penable;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    wire cmd_start = wr && paddr == `A_CMD && pwdata[`K_START];
    wire cmd_elrst = wr && paddr == `A_CMD && pwdata[`K_ELRST];
    wire count_wr = wr && paddr == `A_RCOUNT;
    // read path with faults
    wire [21:0] raw = storage_module[cyc_addr_q];
    wire [21:0] register_input = (raw | f1_q) & ~f0_q; // R8
    reg [5:0] s_calc;
    reg [21:0] flip;
    reg single_e, double_e;
    reg [1:0] bpar;
    reg [5:0] spare_col;
    integer k;
    always @* begin
        s_calc = synd(storage_data_register);
        // R9 R10
        case (tsel_q[3:0])
            4'd1: s_calc = s_calc ^ 6'h01;
            4'd2: s_calc = s_calc ^ 6'h04;
            4'd3: s_calc = s_calc ^ 6'h10;
            4'd4: s_calc = s_calc ^ 6'h02;
            4'd5: s_calc = s_calc ^ 6'h08;
            4'd6: s_calc = s_calc ^ 6'h20;
            4'd7, 4'd8, 4'd9: s_calc = s_calc ^ 6'h03;
            default: s_calc = s_calc;
        endcase
        case (tsel_q[7:4])
            4'd1: s_calc = s_calc ^ 6'h02;
            4'd2: s_calc = s_calc ^ 6'h08;
            4'd3: s_calc = s_calc ^ 6'h20;
            4'd4: s_calc = s_calc ^ 6'h01;
            4'd5: s_calc = s_calc ^ 6'h04;
            4'd6: s_calc = s_calc ^ 6'h10;
            4'd7, 4'd8, 4'd9, 4'd11, 4'd12, 4'd13:
                s_calc = s_calc ^ 6'h0c;
            default: s_calc = s_calc;
        endcase
        flip = 22'h000000;
        spare_col = 6'h00;
        for (k = 0; k < 22; k = k + 1) begin
            if (col(k[4:0]) == s_calc)
                flip[k] = 1'b1;
            if (col(k[4:0]) == rspare_q)
                spare_col[0] = spare_col[0]; // R16
        end
        single_e = ^s_calc; // R6
        double_e = (s_calc != 6'h00) & ~(^s_calc); // R7
        bpar[0] = ~^storage_data_register[7:0]; // R5
        bpar[1] = ~^storage_data_register[15:8];
    end
    wire [21:0] corrected = storage_data_register ^
        (corr_fail_q ? 22'h000000 : flip);
    reg [21:0] spare_row;
    always @* begin
        spare_row = 22'h000000;
        for (k = 0; k < 22; k = k + 1)
            if (col(k[4:0]) == rspare_q)
                spare_row[k] = 1'b1; // R15
    end
    wire par_ok = (^{wdata_q[16], wdata_q[7:0]}) &
        (^{wdata_q[17], wdata_q[15:8]}); // R2
    reg [21:0] spare_plane [0:`WORDS-1];
    wire free_tick = ctrl_q[`C_FREE] && free_cnt_q == FREE_CYC - 16'd1;
    wire go = st_q == S_IDLE && (start_q || free_tick || recon_q);
    always @(posedge mclk) begin
        if (!rst_n) begin // R21
            ctrl_q <= 4'h0;
            addr_q <= 13'h0000;
            wdata_q <= 18'h00000;
            f1_q <= 22'h000000;
            f0_q <= 22'h000000;
            tsel_q <= 8'h00;
            rstart_q <= 13'h0000;
            rcount_q <= 13'h0000;
            rspare_q <= 6'h00;
            recon_q <= 1'b0;
            st_q <= S_IDLE;
            cyc_addr_q <= 13'h0000;
            cyc_wr_q <= 1'b0;
            storage_data_register <= 22'h000000;
            bit_err_q <= 22'h000000;
            corr_fail_q <= 1'b0;
            free_cnt_q <= 16'h0000;
            start_q <= 1'b0;
            write_complete_q <= 1'b0;
            host_parity_err_q <= 1'b0;
            double_err_q <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            if (rd_acc) begin
                case (paddr)
                    `A_CTRL: prdata <= {28'h0000000, ctrl_q};
                    `A_ADDR: prdata <= {19'h00000, addr_q};
                    `A_WDATA: prdata <= {14'h0000, wdata_q};
                    `A_FAULT1: prdata <= {10'h000, f1_q};
                    `A_FAULT0: prdata <= {10'h000, f0_q};
                    `A_TSEL: prdata <= {24'h000000, tsel_q};
                    `A_RSTART: prdata <= {19'h00000, rstart_q};
                    `A_RSPARE: prdata <= {26'h0000000, rspare_q};
                    `A_RCOUNT: prdata <= {19'h00000, rcount_q};
                    `A_STATUS: prdata <= {26'h0000000, recon_q,
                        corr_fail_q, double_err_q, host_parity_err_q,
                        write_complete_q, busy};
                    `A_RDATA: prdata <= {14'h0000, bpar,
                        storage_data_register[15:0]};
                    `A_BITERR: prdata <= {10'h000, bit_err_q};
                    `A_DISP: prdata <= {16'h0000, data_display};
                    default: prdata <= 32'h00000000;
                endcase
            end
            if (wr) begin
                case (paddr)
                    `A_CTRL: ctrl_q <= pwdata[3:0];
                    `A_ADDR: addr_q <= pwdata[12:0]; // R1
                    `A_WDATA: wdata_q <= pwdata[17:0];
                    `A_FAULT1: f1_q <= pwdata[21:0];
                    `A_FAULT0: f0_q <= pwdata[21:0] & ~f1_q;
                    `A_TSEL: tsel_q <= pwdata[7:0];
                    `A_RSTART: rstart_q <= pwdata[12:0]; // R13
                    `A_RSPARE: rspare_q <= pwdata[5:0];
                    default: ;
                endcase
            end
            free_cnt_q <= free_tick || !ctrl_q[`C_FREE] ? 16'h0000 :
                free_cnt_q + 16'd1; // R11
            if (cmd_start && !ctrl_q[`C_FREE])
                start_q <= 1'b1;
            else if (go)
                start_q <= 1'b0;
            if (count_wr) begin
                rcount_q <= pwdata[12:0];
                recon_q <= pwdata[12:0] != 13'h0000; // R14
            end
            // latch reset first so a same-cycle set wins
            if (cmd_elrst) begin // R21
                bit_err_q <= 22'h000000;
                double_err_q <= 1'b0;
                host_parity_err_q <= 1'b0;
                corr_fail_q <= 1'b0;
            end
            case (st_q)
                S_IDLE: if (go) begin
                    write_complete_q <= 1'b0; // R17
                    cyc_addr_q <= recon_q ? rstart_q : addr_q;
                    if (!recon_q && ctrl_q[`C_RW] && !par_ok)
                        host_parity_err_q <= 1'b1; // R3
                    cyc_wr_q <= recon_q |
                        (ctrl_q[`C_RW] & par_ok);
                    st_q <= S_READ;
                end
                S_READ: begin
                    storage_data_register <= register_input; // R5
                    st_q <= S_WRITE;
                end
                default: begin
                    if (recon_q) begin // R12
                        storage_module[cyc_addr_q] <= corrected;
                        spare_plane[cyc_addr_q] <= corrected & spare_row;
                        rstart_q <= rstart_q + 13'd1; // R22
                        rcount_q <= rcount_q - 13'd1;
                        if (rcount_q == 13'd1)
                            recon_q <= 1'b0;
                    end else if (cyc_wr_q) begin // R4
                        storage_module[cyc_addr_q] <=
                            {checks(wdata_q[15:0]), wdata_q[15:0]};
                        write_complete_q <= 1'b1;
                    end
                    bit_err_q <= single_e ? flip : 22'h000000; // R6
                    corr_fail_q <= tsel_q[7:4] == 4'd14; // R10
                    if (double_e)
                        double_err_q <= 1'b1; // R7
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
    assign busy = st_q != S_IDLE; // R18
    assign cycle_status_a = st_q != S_IDLE;
    assign bit_error_row = ctrl_q[`C_DSPARE] ? spare_row : bit_err_q; // R19
    assign data_display = ctrl_q[`C_DDATA] ? register_input[15:0] :
        storage_data_register[15:0]; // R20
endmodule // ftm
`default_nettype wire

// ==== ftm_sva.sv ====
// port checker for the fault tolerant memory translator
// assumes one clock, zero wait apb and two clock memory cycles
`default_nettype none
module ftm_sva (
    input wire mclk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire busy,
    input wire cycle_status_a,
    input wire write_complete_q,
    input wire host_parity_err_q,
    input wire double_err_q,
    input wire [21:0] bit_error_row
);
    timeunit 1ns;
    timeprecision 1ps;
    wire elr = psel && penable && pwrite && paddr == 12'h034 && pwdata[1];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_elrst;
        elr;
    endsequence
    sequence s_cycle;
        busy ##1 !busy;
    endsequence
    AST_ZERO_WAIT: assert property (psel && penable |-> pready && !pslverr)
        else $error("apb access not answered at once");
    AST_BUSY_ADV: assert property (busy == cycle_status_a)
        else $error("busy and cycle_status_a differ");
    AST_BUSY_LEN: assert property ($rose(busy) |=> s_cycle)
        else $error("memory cycle length wrong");
    AST_WC_CLR: assert property ($rose(busy) |-> ##[0:1] !write_complete_q)
        else $error("write complete not cleared at cycle start");
    AST_WC_SET: assert property ($rose(write_complete_q) |-> $past(busy) || $past(busy, 2))
        else $error("write complete without a cycle");
    AST_ROW_ONEHOT: assert property ($onehot0(bit_error_row))
        else $error("more than one bit error light");
    AST_LATCH_CLR: assert property (s_elrst |-> ##[1:2] !host_parity_err_q && !double_err_q)
        else $error("error latches not cleared");
    AST_PAR_STICKY: assert property ($fell(host_parity_err_q) |-> $past(elr) || $past(elr, 2))
        else $error("parity latch dropped by itself");
    AST_DBL_STICKY: assert property ($fell(double_err_q) |-> $past(elr) || $past(elr, 2))
        else $error("double latch dropped by itself");
endmodule // ftm_sva
bind ftm ftm_sva chk_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .busy(busy),
    .cycle_status_a(cycle_status_a), .write_complete_q(write_complete_q),
    .host_parity_err_q(host_parity_err_q), .double_err_q(double_err_q),
    .bit_error_row(bit_error_row));
`default_nettype wire

// ==== host_apb.sv ====
// operator side model: apb master for the translator registers
// assumes the slave answers whenever pready is high
`default_nettype none
module host_apb (
    input wire logic mclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // odd parity per byte above the data
    function automatic logic [17:0] wd(input logic [15:0] d);
        return {~^d[15:8], ~^d[7:0], d};
    endfunction
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule // host_apb
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the translator
// assumes the register map of ftm_defs.vh
`default_nettype none
`include "ftm_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    wire psel, penable, pwrite, pready, pslverr, busy, wc, hpe, dbl;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [21:0] row;
    wire adv;
    wire [15:0] disp;
    integer errors = 0, n_compared = 0;
    logic [31:0] r;
    always #2.5 mclk = ~mclk;
    host_apb host_u (.mclk(mclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready));
    ftm dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busy(busy),
        .cycle_status_a(adv), .write_complete_q(wc), .host_parity_err_q(hpe),
        .double_err_q(dbl), .bit_error_row(row), .data_display(disp));
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, r);
    endtask
    // waits until busy has stayed low for eight clocks
    task wait_idle;
        integer k;
        k = 0;
        while (k < 8) begin
            @(negedge mclk);
            check({31'h0, adv}, {31'h0, busy});
            k = (busy === 1'b1) ? 0 : k + 1;
        end
    endtask
    task mem(input logic w, input logic [12:0] a, input logic [17:0] d);
        wr(`A_CTRL, {31'h0, w});
        wr(`A_ADDR, {19'h0, a});
        wr(`A_WDATA, {14'h0, d});
        wr(`A_CMD, 32'h1);
        wait_idle();
        host_u.xfer(1'b0, `A_RDATA, 32'h0, r);
    endtask
    task t_rw;
        mem(1'b1, 13'h1fff, host_u.wd(16'ha5c3));
        check({31'h0, wc}, 32'h1);
        mem(1'b1, 13'h0000, host_u.wd(16'h3c5a));
        mem(1'b0, 13'h1fff, 18'h0);
        check(r, {14'h0, host_u.wd(16'ha5c3)});
        check({31'h0, wc}, 32'h0);
        mem(1'b0, 13'h0000, 18'h0);
        check(r, {14'h0, host_u.wd(16'h3c5a)});
        $display("t_rw done");
    endtask
    task t_badpar;
        mem(1'b1, 13'h1fff, host_u.wd(16'h0f0f) ^ 18'h10000);
        check({31'h0, hpe}, 32'h1);
        check({31'h0, wc}, 32'h0);
        check(r, {14'h0, host_u.wd(16'ha5c3)});
        $display("t_badpar done");
    endtask
    task t_single;
        logic [31:0] m;
        for (int i = 0; i < 16; i++) begin
            m = 32'h1 << i;
            wr(`A_FAULT1, m & ~32'ha5c3);
            wr(`A_FAULT0, m & 32'ha5c3);
            mem(1'b0, 13'h1fff, 18'h0);
            check({10'h0, row}, m);
            check({16'h0, r[15:0]}, {16'h0, 16'ha5c3 ^ m[15:0]});
            check({31'h0, dbl}, 32'h0);
        end
        $display("t_single done");
    endtask
    task t_double;
        wr(`A_FAULT1, 32'h0c);
        wr(`A_FAULT0, 32'h0);
        mem(1'b0, 13'h1fff, 18'h0);
        check({31'h0, dbl}, 32'h1);
        check({10'h0, row}, 32'h0);
        wr(`A_FAULT1, 32'h0);
        wr(`A_CMD, 32'h2);
        wait_idle();
        check({30'h0, hpe, dbl}, 32'h0);
        $display("t_double done");
    endtask
    task t_recon;
        wr(`A_RSTART, 32'h1fff);
        wr(`A_RSPARE, 32'h01);
        wr(`A_RCOUNT, 32'h1);
        wait_idle();
        host_u.xfer(1'b0, `A_STATUS, 32'h0, r);
        check({31'h0, r[5]}, 32'h0);
        mem(1'b0, 13'h1fff, 18'h0);
        check({14'h0, r[17:0]}, {14'h0, host_u.wd(16'ha5c3)});
        $display("t_recon done");
    endtask
    task t_disp;
        wr(`A_FAULT0, 32'h1);
        mem(1'b0, 13'h1fff, 18'h0);
        wr(`A_FAULT0, 32'h0);
        wr(`A_CTRL, 32'h8);
        @(negedge mclk);
        check({16'h0, disp}, 32'ha5c3);
        wr(`A_CTRL, 32'h0);
        @(negedge mclk);
        check({16'h0, disp}, 32'ha5c2);
        wr(`A_CTRL, 32'h4);
        @(negedge mclk);
        check({10'h0, row}, 32'h10000);
        wr(`A_CTRL, 32'h0);
        $display("t_disp done");
    endtask
    task t_free;
        integer cnt;
        logic pb;
        cnt = 0;
        pb = 1'b0;
        wr(`A_CTRL, 32'h2);
        repeat (700) begin
            @(negedge mclk);
            if (busy === 1'b1 && !pb)
                cnt = cnt + 1;
            pb = (busy === 1'b1);
        end
        check(cnt, 32'h2);
        wr(`A_CTRL, 32'h0);
        wait_idle();
        $display("t_free done");
    endtask
    task stop_test;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_rw();
        t_badpar();
        t_single();
        t_double();
        t_recon();
        t_disp();
        t_free();
        stop_test();
    end
    initial begin
        #100000;
        errors = errors + 1;
        stop_test();
    end
endmodule // testbench
`default_nettype wire
